// ==== src/perf_counters_regs.vh ====
// Register selects, field positions and timing counts of the event/duration counters
`ifndef PERF_COUNTERS_REGS_VH
`define PERF_COUNTERS_REGS_VH

// Register selects on the model-register port
`define SEL_CONTROL       2'h0
`define SEL_COUNT_FIRST   2'h1
`define SEL_COUNT_SECOND  2'h2

// Control register fields
`define CTL_RESET         32'h00000000
`define ES_FIRST_LSB      0
`define CC_FIRST_LSB      6
`define PF_FIRST_BIT      9
`define ES_SECOND_LSB     16
`define CC_SECOND_LSB     22
`define PF_SECOND_BIT     25
`define ES_WIDTH          6
`define CC_WIDTH          3

// Count-control code bits
`define CC_DURATION_BIT   2
`define CC_USER_BIT       1
`define CC_SUPER_BIT      0

// Privilege levels: the one allowed to reach the registers, and the user level
`define PRIV_ALLOWED      2'h0
`define PRIV_USER         2'h3

// Pin latency: overflow shows about this many clocks after it occurs
`define PIN_LAG_CLOCKS    5
`define PIN_LAG_STAGES    4

`endif

// ==== src/dual_event_duration_counters.v ====
// Two 40-bit event/duration counters with shared control register and monitor pins
`include "perf_counters_regs.vh"

// Function
// RQ1: Two independent 40-bit counters counting events or clocks.
// RQ2: Registers read and written by model-register access only at privilege 0.
// RQ3: Six-bit event select at bits 0-5 and 16-21.
// RQ4: Three-bit count control at bits 6-8 and 22-24.
// RQ5: Codes 000 and 100 disable the counter; it holds its value.
// RQ6: Top bit clocks, middle bit privilege 3, low bit privilege 0-2.
// RQ7: Pin flag at bit 9/25: one means overflow, zero means increment.
// RQ8: Pin lags internal event; overflow shows about 5 clocks later.
// RQ9: Reset clears the whole control register, disabling both counters.
// RQ10: Software does read-modify-write of the whole control register.
// RQ11: Software stops and presets a counter before changing its event.
// RQ12: Increment pin high each event clock, or whole duration condition.
// RQ13: Overflow is carry out of bit 39 and asserts pin in overflow mode.
// RQ14: Preset counter overflows after the remaining number of events.
// RQ15: Double event in one clock adds 2 while pin asserts once.
// RQ16: Duration counting adds one per clock the condition holds.
// RQ17: Pins default to monitoring; debug mode shows breakpoint matches instead.
// RQ18: Undefined event codes are reserved; their counts are undefined.
// RQ19: On overflow the counter wraps to zero and keeps counting.
module dual_event_duration_counters #(
  parameter CNT_WIDTH = 40,
  parameter NUM_EVENTS = 64
) (
  // Clock and reset
  input  wire                  clock,
  input  wire                  sys_rst,
  // Model-register access port
  input  wire                  modelRegRead,
  input  wire                  modelRegWrite,
  input  wire [1:0]            regSel,
  input  wire [63:0]           regWrData,
  output reg  [63:0]           regRdData,
  output reg                   regAccessFault,
  input  wire [1:0]            currentPrivilegeLevel,
  // Event sources: occurrence counts (two bits per code) and duration levels
  input  wire [2*NUM_EVENTS-1:0] eventOccur,
  input  wire [NUM_EVENTS-1:0] eventLevel,
  input  wire [NUM_EVENTS-1:0] eventIsDuration,
  // Debug repurposing of the pins
  input  wire                  debugPinMode,
  input  wire [1:0]            breakpointMatch,
  // Monitor pins
  output reg                   monitorPinFirst,
  output reg                   monitorPinSecond
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0]          counterControlEventSelect_q;
  reg [CNT_WIDTH-1:0] perfCountFirst_q;
  reg [CNT_WIDTH-1:0] perfCountSecond_q;
  reg [`PIN_LAG_STAGES-1:0] pinPipeFirst_q;
  reg [`PIN_LAG_STAGES-1:0] pinPipeSecond_q;

  wire accessOk = (currentPrivilegeLevel == `PRIV_ALLOWED);      // RQ2
  wire wrOk     = modelRegWrite & accessOk;

  wire [5:0] eventSelFirst  = counterControlEventSelect_q[`ES_FIRST_LSB +: `ES_WIDTH];  // RQ3
  wire [5:0] eventSelSecond = counterControlEventSelect_q[`ES_SECOND_LSB +: `ES_WIDTH]; // RQ3
  wire [2:0] countCtlFirst  = counterControlEventSelect_q[`CC_FIRST_LSB +: `CC_WIDTH];  // RQ4
  wire [2:0] countCtlSecond = counterControlEventSelect_q[`CC_SECOND_LSB +: `CC_WIDTH]; // RQ4
  wire       pinFuncFirst   = counterControlEventSelect_q[`PF_FIRST_BIT];               // RQ7
  wire       pinFuncSecond  = counterControlEventSelect_q[`PF_SECOND_BIT];              // RQ7

  // ----------------------------------------------------------------
  // Step computation shared by both counters
  // ----------------------------------------------------------------
  // Returns {pinActivity, increment[1:0]} for one counter.
  // Reserved codes beyond NUM_EVENTS simply see no event.
  function [2:0] countStep;
    input [2:0]  ctl;
    input [5:0]  sel;
    input [1:0]  priv;
    input [2*NUM_EVENTS-1:0] occ;
    input [NUM_EVENTS-1:0]   lvl;
    input [NUM_EVENTS-1:0]   dur;
    reg          privOk;
    reg [1:0]    occN;
    reg          level;
    reg          isDur;
    begin
      // RQ6
      privOk = (priv == `PRIV_USER) ? ctl[`CC_USER_BIT] : ctl[`CC_SUPER_BIT];
      occN   = 2'h0;
      level  = 1'b0;
      isDur  = 1'b0;
      if (sel < NUM_EVENTS) begin  // RQ18
        occN  = occ[2*sel +: 2];
        level = lvl[sel];
        isDur = dur[sel];
      end
      countStep = 3'h0;
      if (privOk) begin  // RQ5
        if (ctl[`CC_DURATION_BIT]) begin
          countStep = {1'b1, 2'h1};  // Clock counting: every enabled clock
        end else if (isDur) begin
          countStep = {level, 1'b0, level};  // RQ16 RQ12
        end else begin
          countStep = {(occN != 2'h0), occN};  // RQ15 RQ12
        end
      end
    end
  endfunction

  wire [2:0] stepFirst  = countStep(countCtlFirst, eventSelFirst, currentPrivilegeLevel,
                                    eventOccur, eventLevel, eventIsDuration);
  wire [2:0] stepSecond = countStep(countCtlSecond, eventSelSecond, currentPrivilegeLevel,
                                    eventOccur, eventLevel, eventIsDuration);

  // RQ13 RQ19: carry out of the top bit marks overflow; the sum wraps
  wire [CNT_WIDTH:0] sumFirst  = {1'b0, perfCountFirst_q}
                               + {{(CNT_WIDTH-1){1'b0}}, stepFirst[1:0]};
  wire [CNT_WIDTH:0] sumSecond = {1'b0, perfCountSecond_q}
                               + {{(CNT_WIDTH-1){1'b0}}, stepSecond[1:0]};
  wire ovfFirst  = sumFirst[CNT_WIDTH];
  wire ovfSecond = sumSecond[CNT_WIDTH];

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      counterControlEventSelect_q <= `CTL_RESET;  // RQ9
    end else if (wrOk && regSel == `SEL_CONTROL) begin
      counterControlEventSelect_q <= regWrData[31:0];  // RQ2
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // A refused write at privilege above zero changes nothing
  // Counter writes take the low 40 bits as they are; no sign extension
  wire loadFirst  = wrOk && (regSel == `SEL_COUNT_FIRST);   // RQ2
  wire loadSecond = wrOk && (regSel == `SEL_COUNT_SECOND);  // RQ2

  // ----------------------------------------------------------------
  // Counter next values
  // ----------------------------------------------------------------
  // Software preset beats the running sum in the same clock, so the
  // loaded value is exact; the count of that one clock is dropped.
  function [CNT_WIDTH-1:0] nextCount;
    input                 load;
    input [CNT_WIDTH-1:0] loadValue;
    input [CNT_WIDTH:0]   sum;
    begin
      if (load) begin
        nextCount = loadValue;  // RQ14
      end else begin
        nextCount = sum[CNT_WIDTH-1:0];  // RQ1 RQ19
      end
    end
  endfunction

  wire [CNT_WIDTH-1:0] perfCountFirst_d  = nextCount(loadFirst, regWrData[CNT_WIDTH-1:0],
                                                     sumFirst);
  wire [CNT_WIDTH-1:0] perfCountSecond_d = nextCount(loadSecond, regWrData[CNT_WIDTH-1:0],
                                                     sumSecond);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Both counters share the control register but run independently.
  // A wrap leaves a counter running; overflow shows only on its pin.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      perfCountFirst_q <= {CNT_WIDTH{1'b0}};
    end else begin
      perfCountFirst_q <= perfCountFirst_d;  // RQ1
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      perfCountSecond_q <= {CNT_WIDTH{1'b0}};
    end else begin
      perfCountSecond_q <= perfCountSecond_d;  // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped select reads as zero; narrow registers are zero-extended
  function [63:0] readMux;
    input [1:0]           sel;
    input [31:0]          ctl;
    input [CNT_WIDTH-1:0] first;
    input [CNT_WIDTH-1:0] second;
    begin
      case (sel)
        `SEL_CONTROL:      readMux = {32'h00000000, ctl};
        `SEL_COUNT_FIRST:  readMux = {{(64-CNT_WIDTH){1'b0}}, first};
        `SEL_COUNT_SECOND: readMux = {{(64-CNT_WIDTH){1'b0}}, second};
        default:           readMux = 64'h0000000000000000;
      endcase
    end
  endfunction

  wire readOk    = modelRegRead & accessOk;                     // RQ2
  wire faultNext = (modelRegRead | modelRegWrite) & ~accessOk;  // RQ2

  // Read data stands until the next accepted read; a refused read leaves it.
  // Read and write in one clock: the read returns the old value.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData      <= 64'h0000000000000000;
      regAccessFault <= 1'b0;
    end else begin
      regAccessFault <= faultNext;  // RQ2
      if (readOk) begin
        regRdData <= readMux(regSel, counterControlEventSelect_q,
                             perfCountFirst_q, perfCountSecond_q);  // RQ2
      end
    end
  end

  // ----------------------------------------------------------------
  // Debug inputs
  // ----------------------------------------------------------------
  // The debugger runs on its own clock. Three stages; a bit changes only
  // once the last two stages agree, so a late sample cannot flash a pin.
  // Cost: the breakpoint view lags its source by four clocks.
  // Reset clears every stage, so the pins start in monitoring use.
  wire [2:0] debugRaw = {debugPinMode, breakpointMatch};
  reg  [2:0] debugMeta_q;
  reg  [2:0] debugSettle_q;
  reg  [2:0] debugAgree_q;
  reg  [2:0] debugFilt_q;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      debugMeta_q   <= 3'h0;
      debugSettle_q <= 3'h0;
      debugAgree_q  <= 3'h0;
      debugFilt_q   <= 3'h0;
    end else begin
      debugMeta_q   <= debugRaw;
      debugSettle_q <= debugMeta_q;
      debugAgree_q  <= debugSettle_q;
      // Per bit: agreeing high sets, agreeing low clears, else hold
      debugFilt_q   <= (debugSettle_q & debugAgree_q)
                     | (debugFilt_q & (debugSettle_q | debugAgree_q));  // RQ17
    end
  end

  wire       debugMode      = debugFilt_q[2];
  wire [1:0] breakpointSeen = debugFilt_q[1:0];

  // ----------------------------------------------------------------
  // Monitor pins
  // ----------------------------------------------------------------
  // Increment mode shows activity, not the step: a double event is one pulse
  function pinSource;
    input pinFunc;
    input overflow;
    input activity;
    begin
      pinSource = pinFunc ? overflow : activity;  // RQ7
    end
  endfunction

  wire pinSrcFirst  = pinSource(pinFuncFirst, ovfFirst, stepFirst[2]);     // RQ13 RQ15
  wire pinSrcSecond = pinSource(pinFuncSecond, ovfSecond, stepSecond[2]);  // RQ13 RQ15

  // Source in cycle k shows on the pin in cycle k+5: four pipe stages
  // and the output flop. An overflow is a one-clock pulse.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinPipeFirst_q  <= {`PIN_LAG_STAGES{1'b0}};
      pinPipeSecond_q <= {`PIN_LAG_STAGES{1'b0}};
    end else begin
      pinPipeFirst_q  <= {pinPipeFirst_q[`PIN_LAG_STAGES-2:0], pinSrcFirst};    // RQ8
      pinPipeSecond_q <= {pinPipeSecond_q[`PIN_LAG_STAGES-2:0], pinSrcSecond};  // RQ8
    end
  end

  // Breakpoint indication hides monitoring while debug mode holds.
  // The pipeline keeps running, so monitoring resumes without a gap.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      monitorPinFirst  <= 1'b0;
      monitorPinSecond <= 1'b0;
    end else begin
      monitorPinFirst  <= debugMode ? breakpointSeen[0]
                                    : pinPipeFirst_q[`PIN_LAG_STAGES-1];   // RQ17
      monitorPinSecond <= debugMode ? breakpointSeen[1]
                                    : pinPipeSecond_q[`PIN_LAG_STAGES-1];  // RQ17
    end
  end

endmodule

// ==== tb/perf_counters_monitor.sv ====
// Port checker for the dual event/duration counters
module perf_counters_monitor (
  // Clock and reset
  input logic        clock,
  input logic        sys_rst,
  // Register port
  input logic        modelRegRead,
  input logic        modelRegWrite,
  input logic [1:0]  regSel,
  input logic [63:0] regWrData,
  input logic [63:0] regRdData,
  input logic        regAccessFault,
  input logic [1:0]  currentPrivilegeLevel,
  // Pins
  input logic        monitorPinFirst,
  input logic        monitorPinSecond
);
  timeunit 1ns;
  timeprecision 1ns;
  wire anyAcc = modelRegRead | modelRegWrite;
  wire privOk = currentPrivilegeLevel == 2'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_fault_on_deny: assert property (anyAcc && !privOk |=> regAccessFault)
    else $error("fault missing after denied access");
  chk_no_stray_fault: assert property (!(anyAcc && !privOk) |=> !regAccessFault)
    else $error("fault without denied access");
  chk_read_hold: assert property (!(modelRegRead && privOk) |=> $stable(regRdData))
    else $error("read data moved without accepted read");
  chk_unmapped_zero: assert property (modelRegRead && privOk && regSel == 2'h3 |=>
    regRdData == 64'h0) else $error("unmapped read not zero");
  chk_count_width: assert property (modelRegRead && privOk && regSel[0] != regSel[1] |=>
    regRdData[63:40] == 24'h0) else $error("counter read wider than 40 bits");
  chk_ctl_width: assert property (modelRegRead && privOk && regSel == 2'h0 |=>
    regRdData[63:32] == 32'h0) else $error("control read wider than 32 bits");
  chk_ctl_readback: assert property (modelRegWrite && privOk && regSel == 2'h0 ##1 !anyAcc
    ##1 modelRegRead && privOk && regSel == 2'h0 |=> regRdData[31:0] == $past(regWrData[31:0], 3))
    else $error("control readback differs from write");
  chk_reset_clear: assert property ($fell(sys_rst) |-> regRdData == 64'h0 && !regAccessFault
    && !monitorPinFirst && !monitorPinSecond) else $error("outputs not cleared by reset");
endmodule

bind dual_event_duration_counters perf_counters_monitor perf_counters_monitor_inst (.*);

// ==== tb/pin_watcher.sv ====
// External monitor that tallies high cycles on each counter pin
module pin_watcher (
  input  logic clock,
  input  logic sys_rst,
  input  logic monitorPinFirst,
  input  logic monitorPinSecond,
  output int   highFirst,
  output int   highSecond
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clock) begin
    if (sys_rst) begin
      highFirst <= 0;
      highSecond <= 0;
    end else begin
      highFirst <= highFirst + int'(monitorPinFirst);
      highSecond <= highSecond + int'(monitorPinSecond);
    end
  end
endmodule

// ==== tb/dual_event_duration_counters_tb_top.sv ====
// Self-checking bench for the dual event/duration counters
module dual_event_duration_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock = 0, sys_rst = 1, modelRegRead = 0, modelRegWrite = 0, debugPinMode = 0;
  logic [1:0]   regSel = 2'h0, currentPrivilegeLevel = 2'h0, breakpointMatch = 2'h0;
  logic [63:0]  regWrData = 64'h0, regRdData, rd, eventLevel = 64'h0, eventIsDuration = 64'h0;
  logic [127:0] eventOccur = 128'h0;
  logic         regAccessFault, monitorPinFirst, monitorPinSecond, flt;
  int           failures = 0, samples_checked = 0, highFirst, highSecond, b, c;
  dual_event_duration_counters dual_event_duration_counters_inst (
    .clock(clock), .sys_rst(sys_rst), .modelRegRead(modelRegRead),
    .modelRegWrite(modelRegWrite), .regSel(regSel), .regWrData(regWrData),
    .regRdData(regRdData), .regAccessFault(regAccessFault),
    .currentPrivilegeLevel(currentPrivilegeLevel), .eventOccur(eventOccur),
    .eventLevel(eventLevel), .eventIsDuration(eventIsDuration),
    .debugPinMode(debugPinMode), .breakpointMatch(breakpointMatch),
    .monitorPinFirst(monitorPinFirst), .monitorPinSecond(monitorPinSecond));
  pin_watcher pin_watcher_inst (
    .clock(clock), .sys_rst(sys_rst), .monitorPinFirst(monitorPinFirst),
    .monitorPinSecond(monitorPinSecond), .highFirst(highFirst), .highSecond(highSecond));
  initial forever #50 clock = ~clock;
  task automatic check(input logic [63:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(bit w, logic [1:0] s, logic [63:0] d, logic [1:0] p = 2'h0);
    @(posedge clock);
    {modelRegWrite, modelRegRead, regSel, regWrData, currentPrivilegeLevel} <= {w, !w, s, d, p};
    @(posedge clock);
    {modelRegWrite, modelRegRead, currentPrivilegeLevel} <= 4'h0;
    @(negedge clock);
    rd = regRdData;
    flt = regAccessFault;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int s = 0; s < 4; s++) begin
      acc(0, s[1:0], 64'h0);
      check(rd, 64'h0, "reset read");
    end
  endtask
  task automatic t_deny;
    acc(1, 2'h0, 64'h3c1, 2'h3);
    check(flt, 1'b1, "fault");
    acc(0, 2'h0, 64'h0);
    check(rd, 64'h0, "ctl after deny");
    acc(1, 2'h0, 64'h0200_0241);
    acc(0, 2'h0, 64'h0);
    check(rd, 64'h0200_0241, "ctl fields");
    acc(1, 2'h0, (rd & ~64'h03ff_0000) | 64'h0001_0000);
    acc(0, 2'h0, 64'h0);
    check(rd, 64'h0001_0241, "ctl rmw");
    acc(1, 2'h0, 64'h0);
  endtask
  task automatic t_codes;
    int cc[7] = '{0, 4, 2, 1, 3, 2, 1};
    int pv[7] = '{0, 0, 0, 0, 0, 3, 3};
    int ex[7] = '{0, 0, 0, 2, 2, 2, 0};
    for (int i = 0; i < 7; i++) begin
      acc(1, 2'h1, 64'h0);
      acc(1, 2'h0, 64'h1 | 64'(cc[i] << 6));
      b = highFirst;
      @(posedge clock);
      {eventOccur[3:2], currentPrivilegeLevel} <= {2'h2, pv[i][1:0]};
      @(posedge clock);
      {eventOccur[3:2], currentPrivilegeLevel} <= 4'h0;
      repeat (8) @(posedge clock);
      check(highFirst - b, ex[i] != 0, "occurrence pin");
      acc(1, 2'h0, 64'h0);
      acc(0, 2'h1, 64'h0);
      check(rd, ex[i], "first count");
    end
  endtask
  task automatic t_duration;
    acc(1, 2'h1, 64'h0);
    acc(1, 2'h0, 64'hc1);
    b = highFirst;
    @(posedge clock);
    {eventIsDuration[1], eventLevel[1]} <= 2'h3;
    repeat (3) @(posedge clock);
    eventLevel[1] <= 1'b0;
    repeat (8) @(posedge clock);
    eventIsDuration[1] <= 1'b0;
    check(highFirst - b, 64'd3, "duration pin");
    acc(1, 2'h0, 64'h0);
    acc(0, 2'h1, 64'h0);
    check(rd, 64'd3, "duration count");
  endtask
  task automatic t_overflow;
    acc(1, 2'h2, 64'hff_ffff_fffe);
    b = highSecond;
    acc(1, 2'h0, 64'h03c0_0000);
    repeat (5) @(posedge clock);
    @(negedge clock);
    check(monitorPinSecond, 1'b0, "overflow pin early");
    @(negedge clock);
    check(monitorPinSecond, 1'b1, "overflow pin lag");
    @(negedge clock);
    check(monitorPinSecond, 1'b0, "overflow pin pulse");
    repeat (5) @(posedge clock);
    acc(1, 2'h0, 64'h0);
    check(highSecond - b, 64'd1, "overflow pin");
    acc(0, 2'h2, 64'h0);
    check(rd, 64'hc, "wrapped count");
  endtask
  task automatic t_debug;
    b = highFirst;
    c = highSecond;
    @(posedge clock);
    {debugPinMode, breakpointMatch} <= 3'h5;
    repeat (3) @(posedge clock);
    breakpointMatch <= 2'h0;
    repeat (8) @(posedge clock);
    debugPinMode <= 1'b0;
    check(highFirst - b, 64'd3, "breakpoint pin");
    check(highSecond - c, 64'd0, "idle pin");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_deny();
    t_codes();
    t_duration();
    t_overflow();
    t_debug();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    finish_test();
  end
endmodule
